// file: hdl/shs_consts.svh
`ifndef SHS_CONSTS_SVH
`define SHS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and delay figures
// ----------------------------------------------------------------------------
`define SHS_CLK_MHZ            100
`define SHS_GOOD_DELAY_MS      200
`define SHS_GOOD_DELAY_CYC     (`SHS_GOOD_DELAY_MS * 1000 * `SHS_CLK_MHZ)
`define SHS_ON_TIME_MS         450
`define SHS_ON_TIME_CYC        (`SHS_ON_TIME_MS * 1000 * `SHS_CLK_MHZ)
`define SHS_SEQ_LIMIT_MS       20
`define SHS_SEQ_LIMIT_CYC      (`SHS_SEQ_LIMIT_MS * 1000 * `SHS_CLK_MHZ)
`define SHS_HOLDUP_MS          16
`define SHS_HOLDUP_CYC         (`SHS_HOLDUP_MS * 1000 * `SHS_CLK_MHZ)
`define SHS_WARN_MS            1
`define SHS_WARN_CYC           (`SHS_WARN_MS * 1000 * `SHS_CLK_MHZ)
`define SHS_OFF_MIN_MS         1000
`define SHS_OFF_MIN_CYC        (`SHS_OFF_MIN_MS * 1000 * `SHS_CLK_MHZ)
`define SHS_DEBOUNCE_US        10000
`define SHS_DEBOUNCE_CYC       (`SHS_DEBOUNCE_US * `SHS_CLK_MHZ)
`define SHS_STBY_DELAY_US      1000
`define SHS_STBY_DELAY_CYC     (`SHS_STBY_DELAY_US * `SHS_CLK_MHZ)

`endif

// file: hdl/shs_pkg.sv
package shs_pkg;

	typedef struct packed {
		logic p12;
		logic p5;
		logic p3v3;
	} shs_rails_t;

	typedef enum logic [4:0] {
		ST_OFF     = 5'h01,
		ST_RAMP    = 5'h02,
		ST_DELAY   = 5'h04,
		ST_RUN     = 5'h08,
		ST_FAULT   = 5'h10
	} shs_state_t;

endpackage : shs_pkg

// file: hdl/shs_sequencer.sv
// Notes on behaviour
// - Good only while rails good and energy stored
// - Good drops on rail undervoltage or mains loss
// - Good rises 100..500 ms after regulation
// - Good holds at least 16 ms after mains loss
// - Good falls 1 ms before rails drop; the code leads only on mains loss
// - Low request enables all four main rails; the code has three (p12, p5, p3v3)
// - High or open request keeps rails disabled
// - Standby rail on whenever mains present
// - Undriven request reads as power off
// - Request input is debounced
// - Rails regulate within 500 ms of request
// - Standby up within two seconds of mains
// - Rail ramp between 0.2 and 20 ms
// - 3.3 V follows others within 20 ms
// - Fault clears after fault gone, 1 s off, reassert
// - Outputs held up 17 ms after mains loss
// - Short on main rail latches off
// - Over-voltage on main rail latches off
// - Fan off while request high
`include "shs_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module shs_sequencer
	import shs_pkg::*;
#(
	parameter int unsigned GOOD_DELAY_CYC = `SHS_GOOD_DELAY_CYC,
	parameter int unsigned ON_TIME_CYC    = `SHS_ON_TIME_CYC,
	parameter int unsigned SEQ_LIMIT_CYC  = `SHS_SEQ_LIMIT_CYC,
	parameter int unsigned HOLDUP_CYC     = `SHS_HOLDUP_CYC,
	parameter int unsigned WARN_CYC       = `SHS_WARN_CYC,
	parameter int unsigned OFF_MIN_CYC    = `SHS_OFF_MIN_CYC,
	parameter int unsigned DEBOUNCE_CYC   = `SHS_DEBOUNCE_CYC,
	parameter int unsigned STBY_DELAY_CYC = `SHS_STBY_DELAY_CYC
) (
	// Clock and reset
	input  wire logic       CLOCK,
	input  wire logic       ARST_N,
	// Board request, already pulled up at the pad
	input  wire logic       SUPPLY_ON_REQUEST_N,
	// Mains and rail monitors
	input  wire logic       MAINS_PRESENT,
	input  wire shs_rails_t RAIL_GOOD,
	input  wire shs_rails_t RAIL_SHORT,
	input  wire shs_rails_t RAIL_OVERVOLT,
	// Rail controls
	output logic            MAIN_RAILS_EN,
	output logic            RAIL_3V3_EN,
	output logic            STANDBY_RAIL_EN,
	output logic            FAN_EN,
	// Status
	output logic            SUPPLY_GOOD,
	output logic            FAULT_LATCHED
);

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	localparam int SW = 11;
	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	wire  [SW-1:0] raw_in = {SUPPLY_ON_REQUEST_N, MAINS_PRESENT, RAIL_GOOD, RAIL_SHORT, RAIL_OVERVOLT};

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			sync1_q <= 11'h400;
			sync2_q <= 11'h400;
		end else begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	wire        req_n_s = sync2_q[10];
	wire        mains_s = sync2_q[9];
	wire [2:0]  good_s  = sync2_q[8:6];
	wire [2:0]  short_s = sync2_q[5:3];
	wire [2:0]  ovp_s   = sync2_q[2:0];
	wire        any_bad = (|short_s) | (|ovp_s);

	// ------------------------------------------------------------------------
	// Request debounce
	// ------------------------------------------------------------------------
	logic        req_q;
	logic [31:0] deb_cnt_q;
	wire         req_raw  = !req_n_s;
	wire         deb_same = (req_raw == req_q);

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			req_q     <= 1'b0;
			deb_cnt_q <= 32'h0;
		end else if (deb_same) begin
			deb_cnt_q <= 32'h0;
		end else if (deb_cnt_q >= DEBOUNCE_CYC - 1) begin
			req_q     <= req_raw;
			deb_cnt_q <= 32'h0;
		end else begin
			deb_cnt_q <= deb_cnt_q + 32'h1;
		end
	end

	// ------------------------------------------------------------------------
	// Standby start-up
	// ------------------------------------------------------------------------
	logic        stby_ok_q;
	logic [31:0] stby_cnt_q;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			stby_ok_q  <= 1'b0;
			stby_cnt_q <= 32'h0;
		end else if (!mains_s) begin
			// Standby rides through the hold-up span so the main rails are not cut early
			stby_cnt_q <= 32'h0;
			if (loss_rails_q)
				stby_ok_q <= 1'b0;
		end else if (stby_cnt_q >= STBY_DELAY_CYC - 1) begin
			stby_ok_q  <= 1'b1;
		end else begin
			stby_cnt_q <= stby_cnt_q + 32'h1;
		end
	end

	// Standby follows mains only; the main request has no say
	assign STANDBY_RAIL_EN = stby_ok_q;

	// ------------------------------------------------------------------------
	// Off-time measure for fault release
	// ------------------------------------------------------------------------
	logic        off_long_q;
	logic [31:0] off_cnt_q;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			off_long_q <= 1'b0;
			off_cnt_q  <= 32'h0;
		end else if (req_q) begin
			off_long_q <= 1'b0;
			off_cnt_q  <= 32'h0;
		end else if (off_cnt_q >= OFF_MIN_CYC - 1) begin
			off_long_q <= 1'b1;
		end else begin
			off_cnt_q  <= off_cnt_q + 32'h1;
		end
	end

	// ------------------------------------------------------------------------
	// Mains-loss tracking
	// ------------------------------------------------------------------------
	// Good is dropped at the hold-up mark; rails are kept a further warning
	// interval so good leads the rails down on mains loss.
	logic        loss_good_q;
	logic        loss_rails_q;
	logic [31:0] loss_cnt_q;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			loss_good_q  <= 1'b0;
			loss_rails_q <= 1'b0;
			loss_cnt_q   <= 32'h0;
		end else if (mains_s) begin
			loss_good_q  <= 1'b0;
			loss_rails_q <= 1'b0;
			loss_cnt_q   <= 32'h0;
		end else begin
			if (loss_cnt_q >= HOLDUP_CYC - 1)
				loss_good_q <= 1'b1;
			if (loss_cnt_q >= HOLDUP_CYC + WARN_CYC - 1)
				loss_rails_q <= 1'b1;
			if (!loss_rails_q)
				loss_cnt_q <= loss_cnt_q + 32'h1;
		end
	end

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	shs_state_t  st_q;
	shs_state_t  st_d;
	logic [31:0] tmr_q;
	logic [31:0] seq_q;
	logic        good_q;
	logic        v33_en_q;

	wire rails_all   = &good_s;
	wire first_up    = good_s[2] | good_s[1];
	wire power_ok    = stby_ok_q & !loss_rails_q;
	wire seq_expired = first_up & !good_s[0] & (seq_q >= SEQ_LIMIT_CYC);
	wire ramp_late   = (tmr_q >= ON_TIME_CYC);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_OFF: begin
				if (power_ok && req_q)
					st_d = ST_RAMP;
			end
			ST_RAMP: begin
				if (any_bad || seq_expired || ramp_late)
					st_d = ST_FAULT;
				else if (!req_q || !power_ok)
					st_d = ST_OFF;
				else if (rails_all)
					st_d = ST_DELAY;
			end
			ST_DELAY: begin
				if (any_bad)
					st_d = ST_FAULT;
				else if (!req_q || !power_ok)
					st_d = ST_OFF;
				else if (!rails_all)
					st_d = ST_RAMP;
				else if (tmr_q >= GOOD_DELAY_CYC - 1)
					st_d = ST_RUN;
			end
			ST_RUN: begin
				if (any_bad)
					st_d = ST_FAULT;
				else if (!req_q || !power_ok)
					st_d = ST_OFF;
				else if (!rails_all)
					st_d = ST_FAULT;
			end
			ST_FAULT: begin
				if (!any_bad && off_long_q && req_q)
					st_d = ST_RAMP;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q <= ST_OFF;
			tmr_q <= 32'h0;
		end else if (!stby_ok_q) begin
			st_q  <= ST_OFF;
			tmr_q <= 32'h0;
		end else begin
			st_q  <= st_d;
			tmr_q <= (st_d != st_q) ? 32'h0 : tmr_q + 32'h1;
		end
	end

	// 3.3 V is enabled only once a higher rail is good, then must follow in time
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			seq_q    <= 32'h0;
			v33_en_q <= 1'b0;
		end else if (st_d == ST_OFF || st_d == ST_FAULT) begin
			seq_q    <= 32'h0;
			v33_en_q <= 1'b0;
		end else begin
			v33_en_q <= v33_en_q | first_up;
			if (first_up && !good_s[0])
				seq_q <= seq_q + 32'h1;
		end
	end

	// Good is cleared the cycle after a synchronised rail dip or the hold-up mark
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N)
			good_q <= 1'b0;
		else
			good_q <= (st_d == ST_RUN) & rails_all & !loss_good_q;
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	wire rails_on = (st_q == ST_RAMP) | (st_q == ST_DELAY) | (st_q == ST_RUN);

	// Ramp shaping (0.2 to 20 ms) lives in the analog soft-start
	assign MAIN_RAILS_EN = rails_on;
	assign RAIL_3V3_EN   = rails_on & v33_en_q;
	assign FAN_EN        = rails_on & req_q;
	assign SUPPLY_GOOD   = good_q;
	assign FAULT_LATCHED = (st_q == ST_FAULT);

endmodule : shs_sequencer

`default_nettype wire

// file: dv/shs_board_model.sv
`timescale 1ns/100ps
`default_nettype none
module shs_board_model (
	// Clock
	input wire logic clock,
	// Intent from the test
	input wire logic want_on,
	input wire logic bounce,
	// Request line to the supply
	output var logic request_n
);
	initial request_n = 1'b1;
	// Bounce toggles each cycle like a chattering contact
	always @(negedge clock) begin
		if (bounce) begin
			request_n <= ~request_n;
		end else begin
			request_n <= ~want_on;
		end
	end
endmodule : shs_board_model
`default_nettype wire

// file: dv/shs_seq_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module shs_seq_chk
	import shs_pkg::*;
#(
	parameter int unsigned GOOD_DELAY_CYC = 20,
	parameter int unsigned HOLDUP_CYC     = 16,
	parameter int unsigned WARN_CYC       = 4,
	parameter int unsigned DEBOUNCE_CYC   = 5
) (
	// Clock and reset
	input wire logic       CLOCK,
	input wire logic       ARST_N,
	// Inputs
	input wire logic       SUPPLY_ON_REQUEST_N,
	input wire logic       MAINS_PRESENT,
	input wire shs_rails_t RAIL_GOOD,
	input wire shs_rails_t RAIL_SHORT,
	input wire shs_rails_t RAIL_OVERVOLT,
	// Outputs
	input wire logic       MAIN_RAILS_EN,
	input wire logic       RAIL_3V3_EN,
	input wire logic       STANDBY_RAIL_EN,
	input wire logic       FAN_EN,
	input wire logic       SUPPLY_GOOD,
	input wire logic       FAULT_LATCHED
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);
	// Saturating run lengths so long idle spans never wrap
	logic [15:0] off_q, ok_q, loss_q, low_q;
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			{off_q, ok_q, loss_q, low_q} <= '0;
		end else begin
			off_q  <= SUPPLY_ON_REQUEST_N ? off_q + 16'(~&off_q) : '0;
			ok_q   <= &RAIL_GOOD ? ok_q + 16'(~&ok_q) : '0;
			loss_q <= !MAINS_PRESENT ? loss_q + 16'(~&loss_q) : '0;
			low_q  <= !SUPPLY_GOOD ? low_q + 16'(~&low_q) : '0;
		end
	end
	sequence s_dark;
		FAULT_LATCHED && !MAIN_RAILS_EN ##1 FAULT_LATCHED;
	endsequence
	chk_rails_off_req: assert property (off_q > DEBOUNCE_CYC + 4 |-> !MAIN_RAILS_EN && !RAIL_3V3_EN && !FAN_EN)
		else $error("rails or fan on while off");
	chk_good_needs_rails: assert property (SUPPLY_GOOD |-> MAIN_RAILS_EN && RAIL_3V3_EN)
		else $error("good without rails");
	chk_good_drop_rail: assert property (MAINS_PRESENT && !(&RAIL_GOOD) |-> ##[1:5] !SUPPLY_GOOD)
		else $error("good held on low rail");
	chk_good_delay: assert property ($rose(SUPPLY_GOOD) |-> ok_q >= GOOD_DELAY_CYC && ok_q <= 5 * GOOD_DELAY_CYC / 2)
		else $error("good delay wrong");
	chk_good_holdup: assert property ($fell(SUPPLY_GOOD) && loss_q != 0 |-> loss_q >= HOLDUP_CYC)
		else $error("good hold-up short");
	chk_warn_lead: assert property ($fell(MAIN_RAILS_EN) && !MAINS_PRESENT |-> low_q >= WARN_CYC)
		else $error("no warning lead");
	chk_3v3_order: assert property (RAIL_3V3_EN |-> MAIN_RAILS_EN)
		else $error("3v3 enabled before higher rails");
	chk_short_latch: assert property (MAIN_RAILS_EN && |RAIL_SHORT |-> ##[1:6] s_dark)
		else $error("short not latched");
	chk_ovp_latch: assert property (MAIN_RAILS_EN && |RAIL_OVERVOLT |-> ##[1:6] s_dark)
		else $error("overvoltage not latched");
endmodule : shs_seq_chk
bind shs_sequencer shs_seq_chk #(.GOOD_DELAY_CYC(GOOD_DELAY_CYC), .HOLDUP_CYC(HOLDUP_CYC), .WARN_CYC(WARN_CYC),
	.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_shs_seq_chk (.*);
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import shs_pkg::*;
	localparam int GD = 20, HU = 16, WN = 4, OM = 50, DB = 5, SB = 10;
	logic       CLOCK = 1'b0, ARST_N = 1'b0, MAINS_PRESENT = 1'b1;
	logic       want_on = 1'b0, bounce = 1'b0, dip = 1'b0, SUPPLY_ON_REQUEST_N;
	shs_rails_t RAIL_GOOD = '0, RAIL_SHORT = '0, RAIL_OVERVOLT = '0;
	logic       MAIN_RAILS_EN, RAIL_3V3_EN, STANDBY_RAIL_EN, FAN_EN, SUPPLY_GOOD, FAULT_LATCHED;
	int         bad_count = 0, cmp_count = 0, n;
	wire logic [3:0] mon = {FAULT_LATCHED, MAIN_RAILS_EN, SUPPLY_GOOD, STANDBY_RAIL_EN};
	always #5 CLOCK = ~CLOCK;
	// Rails report good half a cycle after their enables, unless dipped
	always @(negedge CLOCK) RAIL_GOOD <= shs_rails_t'({3{~dip}} & {MAIN_RAILS_EN, MAIN_RAILS_EN, RAIL_3V3_EN});
	shs_sequencer #(.GOOD_DELAY_CYC(GD), .ON_TIME_CYC(200), .SEQ_LIMIT_CYC(20), .HOLDUP_CYC(HU), .WARN_CYC(WN),
		.OFF_MIN_CYC(OM), .DEBOUNCE_CYC(DB), .STBY_DELAY_CYC(SB)) u_shs_sequencer (.CLOCK(CLOCK), .ARST_N(ARST_N),
		.SUPPLY_ON_REQUEST_N(SUPPLY_ON_REQUEST_N), .MAINS_PRESENT(MAINS_PRESENT), .RAIL_GOOD(RAIL_GOOD),
		.RAIL_SHORT(RAIL_SHORT), .RAIL_OVERVOLT(RAIL_OVERVOLT), .MAIN_RAILS_EN(MAIN_RAILS_EN),
		.RAIL_3V3_EN(RAIL_3V3_EN), .STANDBY_RAIL_EN(STANDBY_RAIL_EN), .FAN_EN(FAN_EN),
		.SUPPLY_GOOD(SUPPLY_GOOD), .FAULT_LATCHED(FAULT_LATCHED));
	shs_board_model u_shs_board_model (.clock(CLOCK), .want_on(want_on), .bounce(bounce),
		.request_n(SUPPLY_ON_REQUEST_N));
	task automatic check(input logic ok, input string what);
		cmp_count++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask : check
	task automatic cyc(input int k);
		repeat (k) @(negedge CLOCK);
	endtask : cyc
	// Bounded wait on one monitored output, leaves the count in n
	task automatic wait_sig(input int b, input logic lvl);
		n = 0;
		while (mon[b] !== lvl && n < 3000) begin
			@(negedge CLOCK);
			n++;
		end
		check(n < 3000, "wait timed out");
	endtask : wait_sig
	task automatic recycle();
		want_on = 1'b0;
		cyc(OM + DB + 10);
		want_on = 1'b1;
		wait_sig(1, 1'b1);
	endtask : recycle
	task automatic end_of_test();
		$display("Checks %0d, errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	initial begin
		cyc(5);
		ARST_N = 1'b1;
		cyc(SB + 10);
		check(STANDBY_RAIL_EN === 1'b1, "standby off");
		check(MAIN_RAILS_EN === 1'b0, "rails on at start");
		bounce = 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(negedge CLOCK);
			check(MAIN_RAILS_EN === 1'b0, "bounce passed");
		end
		bounce = 1'b0;
		want_on = 1'b1;
		wait_sig(2, 1'b1);
		cyc(4);
		check(RAIL_3V3_EN === 1'b1, "3v3 off");
		wait_sig(1, 1'b1);
		check(n >= GD, "good early");
		check(FAN_EN === 1'b1, "fan off");
		MAINS_PRESENT = 1'b0;
		wait_sig(1, 1'b0);
		check(n >= HU, "good dropped early");
		wait_sig(2, 1'b0);
		check(n >= WN, "no warning lead");
		want_on = 1'b0;
		MAINS_PRESENT = 1'b1;
		recycle();
		dip = 1'b1;
		wait_sig(1, 1'b0);
		check(n <= 4, "good held on dip");
		wait_sig(3, 1'b1);
		dip = 1'b0;
		cyc(30);
		check(MAIN_RAILS_EN === 1'b0, "fault restarted");
		want_on = 1'b0;
		cyc(OM / 2);
		want_on = 1'b1;
		cyc(DB + 20);
		check(FAULT_LATCHED === 1'b1, "short off cleared");
		recycle();
		check(FAULT_LATCHED === 1'b0, "fault kept");
		for (int k = 0; k < 6; k++) begin
			if (k < 3) RAIL_SHORT = shs_rails_t'(3'h1 << k);
			else RAIL_OVERVOLT = shs_rails_t'(3'h1 << (k - 3));
			cyc(3);
			RAIL_SHORT = '0;
			RAIL_OVERVOLT = '0;
			cyc(3);
			check(FAULT_LATCHED === 1'b1 && MAIN_RAILS_EN === 1'b0, "no latch");
			recycle();
		end
		end_of_test();
	end
	// Far beyond the thousand or so cycles the sequence needs
	initial begin
		#500000;
		bad_count++;
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
